// ===== rtl/mpfp_top.sv
// Pump group fault policy held in the master drive, with an Avalon-MM register slave.
// Assumes fault levels arrive from other drives asynchronously; run and stop requests
// come from logic on i_clk as one-cycle pulses.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "mpfp_defines.svh"

// Overview of operation
// - With the switch bit clear, a fault on the running pump stops every pump.
// - With the switch bit set, a fault on the running pump moves duty to a healthy pump.
// - With the stop-after-reset bit clear, a reset pump is standby and may run again.
// - With the stop-after-reset bit set, a reset pump stays stopped against ordinary control.
// - A pump held stopped after reset is released by an accepted run command, or when the stop-after-reset bit is cleared or the policy stops acting.
// - With the run-with-fault bit clear, a run command is refused while any pump is faulted.
// - With the run-with-fault bit set, a run command starts a non-faulted pump.
// - The policy acts only while this drive is the group master.
// - The policy acts only in auto mode.
// - The policy is a 16-bit word with bits 0 to 2 defined and the rest unused.
// - The start order is cyclic by pump number at 0 and least running time at 1.
module mpfp_top
  import mpfp_pkg::*;
#(
  parameter int N_PUMPS = 4,
  parameter int RT_W = 16,
  parameter int RT_TICK_CYC = `MPFP_RT_TICK_CYC
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [15:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Pump group
  input wire logic [N_PUMPS-1:0] i_pump_fault,
  input wire logic i_run_cmd,
  input wire logic i_stop_cmd,
  output logic [N_PUMPS-1:0] o_pump_run,
  output logic o_run_rejected,
  // Interrupt
  output logic o_irq
);

  localparam int IW = $clog2(N_PUMPS);
  localparam int TW = $clog2(RT_TICK_CYC + 1);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [N_PUMPS-1:0] flt_m_q, flt_m_d, flt_q, flt_d, flt_p_q, flt_p_d;
  logic [N_PUMPS-1:0] hold_q, hold_d, run_q, run_d;
  logic [2:0] policy_q, policy_d;
  logic order_q, order_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [3:0] status_q, status_d, mask_q, mask_d;
  logic ack_q, ack_d, rej_q, rej_d;
  logic [31:0] rdata_q, rdata_d;
  mpfp_grp_type grp_q, grp_d;
  logic [IW-1:0] duty_q, duty_d;
  logic [TW-1:0] tick_q, tick_d;
  logic [N_PUMPS*RT_W-1:0] rt_q, rt_d;

  logic [13:0] idx;
  logic wr_en, active, any_flt, duty_flt;
  logic [N_PUMPS-1:0] flt_rise, flt_fall, elig;
  logic [3:0] ev;
  logic [15:0] state_word;

  mpfp_sel_if #(.N_PUMPS(N_PUMPS), .RT_W(RT_W)) sel ();

  mpfp_pick #(.N_PUMPS(N_PUMPS), .RT_W(RT_W)) u_pick
  (
    .sel(sel)
  );

  // ----------------------------------------
  // Policy qualifiers
  // ----------------------------------------
  // master in auto mode only
  assign active = ctrl_q[`MPFP_CTRL_MASTER] && ctrl_q[`MPFP_CTRL_AUTO];
  assign any_flt = |flt_q;
  assign duty_flt = flt_q[duty_q];
  // Edges come from the settled flags, one stage behind the synchroniser
  assign flt_rise = flt_q & ~flt_p_q;
  assign flt_fall = ~flt_q & flt_p_q;
  assign elig = ~flt_q;

  assign sel.eligible = elig;
  assign sel.current = duty_q;
  assign sel.by_runtime = order_q;
  assign sel.runtime = rt_q;

  // ----------------------------------------
  // Group control
  // ----------------------------------------
  always_comb
  begin
    // Second synchroniser stage is the only reader of the first
    flt_m_d = i_pump_fault;
    flt_d = flt_m_q;
    flt_p_d = flt_q;
    grp_d = grp_q;
    duty_d = duty_q;
    hold_d = hold_q;
    rej_d = 1'b0;
    ev = '0;
    ev[`MPFP_EV_FAULT] = |flt_rise;
    if (active && policy_q[`MPFP_POL_STOP_AFTER])
    begin
      // hold a pump that comes out of fault
      hold_d = hold_d | flt_fall;
    end
    if (!active || !policy_q[`MPFP_POL_STOP_AFTER])
    begin
      hold_d = '0;
    end
    if (i_stop_cmd)
    begin
      grp_d = GRP_IDLE;
    end
    else if (i_run_cmd)
    begin
      if (!active)
      begin
        grp_d = GRP_RUN;
      end
      else if (any_flt && !policy_q[`MPFP_POL_RUN_FAULT])
      begin
        rej_d = 1'b1;
      end
      else if (sel.pick_valid)
      begin
        grp_d = GRP_RUN;
        if (duty_flt || order_q == ORD_BY_RUNTIME)
        begin
          duty_d = sel.pick;
        end
        hold_d = '0;
      end
      else
      begin
        rej_d = 1'b1;
      end
    end
    else if (active && grp_q == GRP_RUN && duty_flt)
    begin
      if (policy_q[`MPFP_POL_ALT_SWITCH] && sel.pick_valid)
      begin
        // move duty away from the faulted pump
        duty_d = sel.pick;
        ev[`MPFP_EV_SWITCH] = 1'b1;
      end
      else
      begin
        grp_d = GRP_IDLE;
        ev[`MPFP_EV_STOPALL] = 1'b1;
      end
    end
    ev[`MPFP_EV_REJECT] = rej_d;
    run_d = '0;
    if (grp_d == GRP_RUN)
    begin
      run_d[duty_d] = 1'b1;
    end
    run_d = run_d & ~hold_d;
  end

  // ----------------------------------------
  // Running time, saturating, one count per unit
  // ----------------------------------------
  always_comb
  begin
    rt_d = rt_q;
    tick_d = tick_q + TW'(1);
    if (tick_q == TW'(RT_TICK_CYC - 1))
    begin
      tick_d = '0;
    end
    for (int i = 0; i < N_PUMPS; i++)
    begin
      if (tick_q == TW'(RT_TICK_CYC - 1) && run_q[i] && ~&rt_q[i*RT_W +: RT_W])
      begin
        rt_d[i*RT_W +: RT_W] = rt_q[i*RT_W +: RT_W] + RT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  // One wait cycle per access keeps the read path registered
  assign idx = i_avs_address[15:2];
  assign wr_en = i_avs_write && ack_q && i_avs_address[1:0] == 2'h0;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;

  always_comb
  begin
    state_word = '0;
    state_word[`MPFP_ST_FAULT +: N_PUMPS] = flt_q;
    state_word[`MPFP_ST_HOLD +: N_PUMPS] = hold_q;
    state_word[`MPFP_ST_RUN +: N_PUMPS] = run_q;
    state_word[`MPFP_ST_DUTY +: IW] = duty_q;
    state_word[`MPFP_ST_GROUP] = grp_q == GRP_RUN;
  end

  always_comb
  begin
    ack_d = (i_avs_read || i_avs_write) && !ack_q;
    rdata_d = rdata_q;
    policy_d = policy_q;
    order_d = order_q;
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    status_d = status_q;
    if (ack_d && i_avs_read)
    begin
      rdata_d = '0;
      if (i_avs_address[1:0] == 2'h0)
      begin
        case (idx)
          // 16-bit word, upper bits read zero
          `MPFP_IDX_POLICY: rdata_d[2:0] = policy_q;
          `MPFP_IDX_ORDER: rdata_d[0] = order_q;
          `MPFP_IDX_STATUS: rdata_d[3:0] = status_q;
          `MPFP_IDX_MASK: rdata_d[3:0] = mask_q;
          `MPFP_IDX_CTRL: rdata_d[1:0] = ctrl_q;
          `MPFP_IDX_STATE: rdata_d[15:0] = state_word;
          default: rdata_d = '0;
        endcase
      end
    end
    if (wr_en)
    begin
      case (idx)
        // only bits 0 to 2 are stored
        `MPFP_IDX_POLICY: policy_d = i_avs_writedata[2:0];
        `MPFP_IDX_ORDER: order_d = i_avs_writedata[0];
        `MPFP_IDX_STATUS: status_d = status_q & ~i_avs_writedata[3:0];
        `MPFP_IDX_MASK: mask_d = i_avs_writedata[3:0];
        `MPFP_IDX_CTRL: ctrl_d = i_avs_writedata[1:0];
        default: status_d = status_d;
      endcase
    end
    // An event in the clearing cycle survives
    status_d = status_d | ev;
  end

  assign o_avs_readdata = rdata_q;
  assign o_pump_run = run_q;
  assign o_run_rejected = rej_q;
  assign o_irq = |(status_q & mask_q);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      flt_m_q <= '0;
      flt_q <= '0;
      flt_p_q <= '0;
      hold_q <= '0;
      run_q <= '0;
      policy_q <= `MPFP_RST_POLICY;
      order_q <= `MPFP_RST_ORDER;
      ctrl_q <= `MPFP_RST_CTRL;
      status_q <= '0;
      mask_q <= `MPFP_RST_MASK;
      ack_q <= 1'b0;
      rej_q <= 1'b0;
      rdata_q <= '0;
      grp_q <= GRP_IDLE;
      duty_q <= '0;
      tick_q <= '0;
      rt_q <= '0;
    end
    else
    begin
      flt_m_q <= flt_m_d;
      flt_q <= flt_d;
      flt_p_q <= flt_p_d;
      hold_q <= hold_d;
      run_q <= run_d;
      policy_q <= policy_d;
      order_q <= order_d;
      ctrl_q <= ctrl_d;
      status_q <= status_d;
      mask_q <= mask_d;
      ack_q <= ack_d;
      rej_q <= rej_d;
      rdata_q <= rdata_d;
      grp_q <= grp_d;
      duty_q <= duty_d;
      tick_q <= tick_d;
      rt_q <= rt_d;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/mpfp_defines.svh
// Register map, field positions, reset values and timing for the pump fault policy block.
// Assumes a 16-bit Avalon byte address with word-aligned registers.
`ifndef MPFP_DEFINES_SVH
`define MPFP_DEFINES_SVH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define MPFP_IDX_POLICY 14'h0C0D
`define MPFP_IDX_ORDER 14'h0C0E
`define MPFP_IDX_STATUS 14'h0C20
`define MPFP_IDX_MASK 14'h0C21
`define MPFP_IDX_CTRL 14'h0C22
`define MPFP_IDX_STATE 14'h0C23

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MPFP_POL_ALT_SWITCH 0
`define MPFP_POL_STOP_AFTER 1
`define MPFP_POL_RUN_FAULT 2
`define MPFP_CTRL_MASTER 0
`define MPFP_CTRL_AUTO 1
`define MPFP_EV_FAULT 0
`define MPFP_EV_REJECT 1
`define MPFP_EV_SWITCH 2
`define MPFP_EV_STOPALL 3
`define MPFP_ST_FAULT 0
`define MPFP_ST_HOLD 4
`define MPFP_ST_RUN 8
`define MPFP_ST_DUTY 12
`define MPFP_ST_GROUP 15

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MPFP_RST_POLICY 3'h1
`define MPFP_RST_ORDER 1'h1
`define MPFP_RST_CTRL 2'h0
`define MPFP_RST_MASK 4'h0

// ----------------------------------------
// Timing: running-time unit of one second
// ----------------------------------------
`define MPFP_CLK_HZ 10000000
`define MPFP_RT_UNIT_S 1
`define MPFP_RT_TICK_CYC (`MPFP_CLK_HZ * `MPFP_RT_UNIT_S)

`endif

// ===== rtl/mpfp_pkg.sv
// Types shared by the pump fault policy block.
// Assumes nothing beyond a SystemVerilog compiler.
package mpfp_pkg;

  // ----------------------------------------
  // Group run state
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    GRP_IDLE = 2'b01,
    GRP_RUN = 2'b10
  } mpfp_grp_type;

  // ----------------------------------------
  // Start-up order selections
  // ----------------------------------------
  typedef enum logic
  {
    ORD_BY_ID = 1'b0,
    ORD_BY_RUNTIME = 1'b1
  } mpfp_order_type;

endpackage

// ===== rtl/mpfp_sel_if.sv
// Carrier between the policy core and the pump selector.
// Assumes both ends share one parameter set.
`timescale 1ns/1ns
`default_nettype none

interface mpfp_sel_if
#(
  parameter int N_PUMPS = 4,
  parameter int RT_W = 16
);
  logic [N_PUMPS-1:0] eligible;
  logic [$clog2(N_PUMPS)-1:0] current;
  logic by_runtime;
  logic [N_PUMPS*RT_W-1:0] runtime;
  logic [$clog2(N_PUMPS)-1:0] pick;
  logic pick_valid;

  modport core (output eligible, current, by_runtime, runtime, input pick, pick_valid);
  modport picker (input eligible, current, by_runtime, runtime, output pick, pick_valid);
endinterface

`default_nettype wire

// ===== rtl/mpfp_pick.sv
// Pump selector: picks the next healthy pump by number or by least running time.
// Assumes a purely combinational use inside the policy core.
`timescale 1ns/1ns
`default_nettype none

module mpfp_pick
  import mpfp_pkg::*;
#(
  parameter int N_PUMPS = 4,
  parameter int RT_W = 16
)
(
  // Selector carrier
  mpfp_sel_if.picker sel
);

  localparam int IW = $clog2(N_PUMPS);

  logic [IW-1:0] pick_v;
  logic found_v;
  logic [RT_W-1:0] best_v;
  int j;

  // ----------------------------------------
  // Selection
  // ----------------------------------------
  always_comb
  begin
    pick_v = '0;
    found_v = 1'b0;
    best_v = '0;
    j = 0;
    if (sel.by_runtime == ORD_BY_RUNTIME)
    begin
      for (int i = 0; i < N_PUMPS; i++)
      begin
        if (sel.eligible[i] && (!found_v || sel.runtime[i*RT_W +: RT_W] < best_v))
        begin
          found_v = 1'b1;
          best_v = sel.runtime[i*RT_W +: RT_W];
          pick_v = IW'(i);
        end
      end
    end
    else
    begin
      for (int k = 1; k <= N_PUMPS; k++)
      begin
        j = int'(sel.current) + k;
        if (j >= N_PUMPS)
        begin
          j = j - N_PUMPS;
        end
        if (!found_v && sel.eligible[j])
        begin
          found_v = 1'b1;
          pick_v = IW'(j);
        end
      end
    end
  end

  assign sel.pick = pick_v;
  assign sel.pick_valid = found_v;

endmodule

`default_nettype wire

// ===== tb/mpfp_slave_model.sv
// Model of the slave drives of the group: reports each pump's fault level.
// Assumes the bench asks for trips and fault resets on i_clk.
`timescale 1ns/1ns
`default_nettype none
module mpfp_slave_model
#(
  parameter int N_PUMPS = 4
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Trip requests and fault levels
  input wire logic [N_PUMPS-1:0] i_trip,
  output logic [N_PUMPS-1:0] o_fault
);
  logic [N_PUMPS-1:0] fault_d;
  logic [N_PUMPS-1:0] fault_q;
  // A drive changes its fault relay only on an edge, never mid-cycle
  always_comb
  begin
    fault_d = i_trip;
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fault_q <= '0;
    end
    else
    begin
      fault_q <= fault_d;
    end
  end
  assign o_fault = fault_q;
endmodule
`default_nettype wire

// ===== tb/mpfp_checker.sv
// Concurrent checks on the pump fault policy block.
// Assumes it is bound to mpfp_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module mpfp_checker
#(
  parameter int N_PUMPS = 4
)
(
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  // Pump group
  input wire logic [N_PUMPS-1:0] i_pump_fault,
  input wire logic i_run_cmd,
  input wire logic i_stop_cmd,
  input wire logic [N_PUMPS-1:0] o_pump_run,
  input wire logic o_run_rejected
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_ack;
    !o_avs_waitrequest;
  endsequence
  // Quiet running group: no command this cycle and no fault seen for four cycles
  sequence s_quiet;
    o_pump_run != '0 && !i_stop_cmd && !i_run_cmd && i_pump_fault == '0
      && $past(i_pump_fault) == '0 && $past(i_pump_fault, 2) == '0
      && $past(i_pump_fault, 3) == '0;
  endsequence
  chk_wait_one: assert property (s_req |=> s_ack)
    else $error("bus wait longer than one cycle");
  chk_wait_first: assert property ($rose(i_avs_read || i_avs_write) |-> s_req)
    else $error("bus answered without a wait cycle");
  chk_wait_idle: assert property (!(i_avs_read || i_avs_write) |-> s_ack)
    else $error("wait raised without a request");
  chk_stop_all: assert property (i_stop_cmd |=> o_pump_run == '0)
    else $error("pumps still run after stop");
  chk_one_duty: assert property ($onehot0(o_pump_run))
    else $error("more than one duty pump");
  chk_reject_cause: assert property (o_run_rejected |-> $past(i_run_cmd))
    else $error("refusal without a run command");
  chk_reject_none: assert property (o_run_rejected |-> (o_pump_run & ~$past(o_pump_run)) == '0)
    else $error("pump started on a refused run");
  chk_run_start: assert property (i_run_cmd && !i_stop_cmd |=> o_pump_run != '0 || o_run_rejected)
    else $error("run neither started nor refused");
  chk_run_holds: assert property (s_quiet |=> $stable(o_pump_run))
    else $error("duty moved without a cause");
endmodule
bind mpfp_top mpfp_checker #(.N_PUMPS(N_PUMPS)) mpfp_checker_i (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .i_pump_fault(i_pump_fault),
  .i_run_cmd(i_run_cmd), .i_stop_cmd(i_stop_cmd), .o_pump_run(o_pump_run),
  .o_run_rejected(o_run_rejected));
`default_nettype wire

// ===== tb/mpfp_top_test.sv
// Self-checking bench for the pump fault policy block.
// Assumes the register map of mpfp_defines.svh and four pumps.
`timescale 1ns/1ns
`default_nettype none
`include "mpfp_defines.svh"
module mpfp_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic wt;
  logic [3:0] trip = '0;
  logic [3:0] flt;
  logic run = 1'b0;
  logic stp = 1'b0;
  logic [3:0] prun;
  logic rej;
  logic irq;
  logic [31:0] d;
  int err_count = 0;
  int checked = 0;
  always #50 clk = ~clk;
  // Short runtime tick keeps the counters moving in a brief run
  mpfp_top #(.RT_TICK_CYC(8)) mpfp_top_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_pump_fault(flt),
    .i_run_cmd(run), .i_stop_cmd(stp), .o_pump_run(prun), .o_run_rejected(rej),
    .o_irq(irq));
  mpfp_slave_model mpfp_slave_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_trip(trip),
    .o_fault(flt));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {idx, 2'b00};
    wdat <= v;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wt !== 1'b0 && n < 20);
    d = rdat;
    if (wt !== 1'b0)
    begin
      err_count++;
      summarize();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [13:0] i, input logic [31:0] v);
    bus(1'b1, i, v);
  endtask
  task automatic rchk(input logic [13:0] i, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, i, '0);
    cmp(d & m, e);
  endtask
  task automatic pulse(input logic s);
    @(posedge clk);
    run <= !s;
    stp <= s;
    @(posedge clk);
    run <= 1'b0;
    stp <= 1'b0;
    #1;
  endtask
  task automatic pchk(input logic [4:0] e);
    cmp(32'({rej, prun}), 32'(e));
  endtask
  task automatic ick(input logic e);
    #1;
    cmp(32'(irq), 32'(e));
  endtask
  // Fault levels pass the model flop and a two-flop synchroniser
  task automatic trip_set(input logic [3:0] t);
    @(posedge clk);
    trip <= t;
    repeat (6) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`MPFP_IDX_POLICY, 32'hFFFF_FFFF, 32'h0000_0001);
    rchk(`MPFP_IDX_ORDER, 32'hFFFF_FFFF, 32'h0000_0001);
    wreg(`MPFP_IDX_POLICY, 32'hFFFF_FFFF);
    rchk(`MPFP_IDX_POLICY, 32'hFFFF_FFFF, 32'h0000_0007);
    rchk(14'h0C30, 32'hFFFF_FFFF, 32'h0000_0000);
    wreg(`MPFP_IDX_ORDER, 32'h0000_0000);
    wreg(`MPFP_IDX_POLICY, 32'h0000_0000);
    $display("test registers done");
    for (int c = 0; c < 3; c++)
    begin
      wreg(`MPFP_IDX_CTRL, 32'(c));
      pulse(1'b0);
      pchk(5'h01);
      trip_set(4'h1);
      pchk(5'h01);
      trip_set(4'h0);
      pulse(1'b1);
      pchk(5'h00);
    end
    $display("test inactive done");
    wreg(`MPFP_IDX_STATUS, 32'h0000_000F);
    wreg(`MPFP_IDX_CTRL, 32'h0000_0003);
    pulse(1'b0);
    pchk(5'h01);
    trip_set(4'h1);
    pchk(5'h00);
    rchk(`MPFP_IDX_STATUS, 32'h0000_0009, 32'h0000_0009);
    ick(1'b0);
    wreg(`MPFP_IDX_MASK, 32'h0000_0008);
    ick(1'b1);
    wreg(`MPFP_IDX_STATUS, 32'h0000_0008);
    ick(1'b0);
    $display("test stop all done");
    pulse(1'b0);
    pchk(5'h10);
    rchk(`MPFP_IDX_STATUS, 32'h0000_0002, 32'h0000_0002);
    trip_set(4'h0);
    rchk(`MPFP_IDX_STATE, 32'h0000_00F0, 32'h0000_0000);
    pulse(1'b0);
    pchk(5'h01);
    pulse(1'b1);
    $display("test refuse done");
    wreg(`MPFP_IDX_POLICY, 32'h0000_0004);
    trip_set(4'h1);
    pulse(1'b0);
    pchk(5'h02);
    wreg(`MPFP_IDX_POLICY, 32'h0000_0005);
    trip_set(4'h5);
    pchk(5'h02);
    trip_set(4'h7);
    pchk(5'h08);
    rchk(`MPFP_IDX_STATUS, 32'h0000_0004, 32'h0000_0004);
    $display("test switch done");
    wreg(`MPFP_IDX_POLICY, 32'h0000_0007);
    trip_set(4'h5);
    rchk(`MPFP_IDX_STATE, 32'h0000_00F0, 32'h0000_0020);
    pchk(5'h08);
    trip_set(4'h0);
    rchk(`MPFP_IDX_STATE, 32'h0000_00F0, 32'h0000_0070);
    pulse(1'b0);
    pchk(5'h08);
    rchk(`MPFP_IDX_STATE, 32'h0000_00F0, 32'h0000_0000);
    pulse(1'b1);
    pchk(5'h00);
    $display("test hold done");
    wreg(`MPFP_IDX_ORDER, 32'h0000_0001);
    // Pump 2 has never run, so it holds the least running time
    pulse(1'b0);
    pchk(5'h04);
    $display("test runtime order done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    pchk(5'h00);
    rchk(`MPFP_IDX_POLICY, 32'hFFFF_FFFF, 32'h0000_0001);
    rchk(`MPFP_IDX_ORDER, 32'hFFFF_FFFF, 32'h0000_0001);
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
